// ===== verilog/mts_trigger_sequencer.sv
`timescale 1ns/1ps
`include "mts_params.svh"
module mts_trigger_sequencer #(
  parameter int DELAY_STEP_CYC = `MTS_DELAY_STEP_NS / `MTS_CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic trig_cfg_wr,
  input wire mts_pkg::mts_trig_cfg_t trig_cfg,
  input wire logic out_cfg_wr,
  input wire mts_pkg::mts_out_cfg_t out_cfg,
  input wire logic trigger_input_connector,
  input wire logic user_io_first_ext,
  input wire logic user_io_second_ext,
  input wire logic manual_trigger,
  input wire logic segmented_sweep,
  input wire logic seq_done,
  input wire logic sweep_begin,
  input wire logic sweep_end,
  input wire logic point_begin,
  input wire logic point_end,
  output logic start_sweep_q,
  output logic start_segment_q,
  output logic start_point_q,
  output logic start_partial_q,
  output logic seq_busy_q,
  output logic trigger_output_connector_q
);
  localparam int WIDTH_UNIT_CYC = `MTS_WIDTH_UNIT_NS / `MTS_CLK_PERIOD_NS;
  localparam int DELAY_MAX_STEPS =
    `MTS_DELAY_MAX_S * (1000000000 / `MTS_DELAY_STEP_NS);
  localparam mts_pkg::mts_multi_cfg_t MULTI_RST = '{
    src: mts_pkg::MTS_MS_FREE, slope1: mts_pkg::MTS_SL_RISE,
    slope2: mts_pkg::MTS_SL_RISE, delay: `MTS_DELAY_RST};
  localparam mts_pkg::mts_trig_cfg_t TRIG_RST = '{
    src: mts_pkg::MTS_SRC_FREE, gran: mts_pkg::MTS_GR_SWEEP,
    slope: mts_pkg::MTS_SL_RISE, first_external_trigger_from_user_io: 1'b0,
    delay: `MTS_DELAY_RST, multi: {4{MULTI_RST}}};
  localparam mts_pkg::mts_out_cfg_t OUT_RST = '{
    enable: 1'b0, width: `MTS_WIDTH_RST, interval_point: 1'b0,
    pos_before: 1'b0, pol_positive: 1'b0};

  if (WIDTH_UNIT_CYC < 1 || DELAY_STEP_CYC < 1 ||
      DELAY_MAX_STEPS >= (1 << `MTS_DELAY_W)) begin : g_chk
    $error("mts_trigger_sequencer: timing constants do not fit the counters");
  end

  typedef enum logic [1:0] {ST_ARMED, ST_DELAY, ST_RUN} mts_state_t;
  mts_state_t state_q;
  mts_pkg::mts_trig_cfg_t cfg_q;
  mts_pkg::mts_out_cfg_t out_cfg_q;
  mts_pkg::mts_multi_cfg_t mcfg;
  logic first_external_trigger_p_q, second_external_trigger_p_q, first_external_trigger_cur, q1, q2, trig_evt;
  logic [`MTS_DELAY_W-1:0] delay_sel;
  logic dly_load, dly_done, out_fire, pulse_active_q, width_done, width_busy;

  // configuration latches, reset to the documented defaults
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= TRIG_RST;
      out_cfg_q <= OUT_RST;
    end else if (clk_en) begin
      if (trig_cfg_wr) begin
        cfg_q <= trig_cfg;
      end
      if (out_cfg_wr) begin
        out_cfg_q <= out_cfg;
        if (out_cfg.width == '0) begin
          out_cfg_q.width <= `MTS_WIDTH_RST;
        end
      end
    end
  end

  // slope or level qualifier of one external line
  function automatic logic qualify(mts_pkg::mts_slope_t sl, logic cur, logic prev);
    unique case (sl)
      mts_pkg::MTS_SL_RISE: qualify = cur & ~prev;
      mts_pkg::MTS_SL_FALL: qualify = ~cur & prev;
      mts_pkg::MTS_SL_HIGH: qualify = cur;
      mts_pkg::MTS_SL_LOW: qualify = ~cur;
    endcase
  endfunction

  // previous samples of the external lines for edge detection
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      first_external_trigger_p_q <= 1'b0;
      second_external_trigger_p_q <= 1'b0;
    end else if (clk_en) begin
      first_external_trigger_p_q <= first_external_trigger_cur;
      second_external_trigger_p_q <= user_io_second_ext;
    end
  end

  // source selection and qualification of the trigger event
  always_comb begin
    first_external_trigger_cur = cfg_q.first_external_trigger_from_user_io ? user_io_first_ext
                                       : trigger_input_connector;
    mcfg = cfg_q.multi[cfg_q.gran];
    q1 = 1'b0;
    q2 = 1'b0;
    trig_evt = 1'b0;
    delay_sel = cfg_q.delay;
    unique case (cfg_q.src)
      mts_pkg::MTS_SRC_FREE: trig_evt = 1'b1;
      mts_pkg::MTS_SRC_EXT: trig_evt = qualify(cfg_q.slope, first_external_trigger_cur, first_external_trigger_p_q);
      mts_pkg::MTS_SRC_MAN: trig_evt = manual_trigger;
      mts_pkg::MTS_SRC_MULTI: begin
        delay_sel = mcfg.delay;
        q1 = qualify(mcfg.slope1, first_external_trigger_cur, first_external_trigger_p_q);
        q2 = qualify(mcfg.slope2, user_io_second_ext, second_external_trigger_p_q);
        case (mcfg.src)
          mts_pkg::MTS_MS_FREE: trig_evt = 1'b1;
          mts_pkg::MTS_MS_FIRST_EXTERNAL_TRIGGER: trig_evt = q1;
          mts_pkg::MTS_MS_SECOND_EXTERNAL_TRIGGER: trig_evt = q2;
          mts_pkg::MTS_MS_AND: trig_evt = q1 & q2;
          mts_pkg::MTS_MS_OR: trig_evt = q1 | q2;
          mts_pkg::MTS_MS_MAN: trig_evt = manual_trigger;
          default: trig_evt = 1'b0;
        endcase
      end
    endcase
  end

  assign dly_load = clk_en && (state_q == ST_ARMED) && trig_evt;

  mts_step_timer #(.STEP_CYC(DELAY_STEP_CYC), .W(`MTS_DELAY_W)) u_delay (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .load(dly_load),
    .steps(delay_sel),
    .done_q(dly_done),
    .busy_q()
  );

  // sequence state: armed, delaying, running; triggers only taken when armed
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_ARMED;
      seq_busy_q <= 1'b0;
    end else if (clk_en) begin
      unique case (state_q)
        ST_ARMED: if (dly_load) begin
          state_q <= ST_DELAY;
          seq_busy_q <= 1'b1;
        end
        ST_DELAY: if (dly_done) begin
          state_q <= ST_RUN;
        end
        ST_RUN: if (seq_done) begin
          state_q <= ST_ARMED;
          seq_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // one-cycle start strobes by granularity once the delay has run out
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      start_sweep_q <= 1'b0;
      start_segment_q <= 1'b0;
      start_point_q <= 1'b0;
      start_partial_q <= 1'b0;
    end else if (clk_en) begin
      start_sweep_q <= 1'b0;
      start_segment_q <= 1'b0;
      start_point_q <= 1'b0;
      start_partial_q <= 1'b0;
      if (state_q == ST_DELAY && dly_done) begin
        unique case (cfg_q.gran)
          mts_pkg::MTS_GR_SWEEP: start_sweep_q <= 1'b1;
          mts_pkg::MTS_GR_SEGMENT: begin
            start_segment_q <= segmented_sweep;
            start_sweep_q <= ~segmented_sweep;
          end
          mts_pkg::MTS_GR_POINT: start_point_q <= 1'b1;
          mts_pkg::MTS_GR_PARTIAL: start_partial_q <= 1'b1;
        endcase
      end
    end
  end

  // output pulse event: per point or per sweep, before or after acquisition
  assign out_fire = clk_en && out_cfg_q.enable && !pulse_active_q &&
    (out_cfg_q.interval_point ? (out_cfg_q.pos_before ? point_begin : point_end)
                              : (out_cfg_q.pos_before ? sweep_begin : sweep_end));

  mts_step_timer #(.STEP_CYC(WIDTH_UNIT_CYC), .W(`MTS_WIDTH_W)) u_width (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .load(out_fire),
    .steps(out_cfg_q.width),
    .done_q(width_done),
    .busy_q(width_busy)
  );

  // pulse window and polarity; a disabled output rests at its idle level
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_active_q <= 1'b0;
      trigger_output_connector_q <= 1'b1;
    end else if (clk_en) begin
      if (!out_cfg_q.enable) begin
        pulse_active_q <= 1'b0;
      end else if (out_fire) begin
        pulse_active_q <= 1'b1;
      end else if (width_done) begin
        pulse_active_q <= 1'b0;
      end
      // gated by the width timer so the line is active exactly width units
      trigger_output_connector_q <= (pulse_active_q & width_busy & out_cfg_q.enable) ^
                                    ~out_cfg_q.pol_positive;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_start_after_delay;
    $rose(start_sweep_q | start_segment_q | start_point_q | start_partial_q) |->
      $past(state_q == ST_DELAY) && $past(dly_done);
  endproperty
  a_start_after_delay: assert property (p_start_after_delay)
    else $error("start strobe without elapsed delay");

  property p_segment_start;
    start_segment_q |-> $past(cfg_q.gran == mts_pkg::MTS_GR_SEGMENT) && $past(segmented_sweep);
  endproperty
  a_segment_start: assert property (p_segment_start)
    else $error("segment start without segmented sweep");

  property p_partial_start;
    start_partial_q |-> $past(cfg_q.gran == mts_pkg::MTS_GR_PARTIAL) && !start_point_q;
  endproperty
  a_partial_start: assert property (p_partial_start)
    else $error("partial start at wrong granularity");

  property p_manual_only;
    (state_q == ST_DELAY && $past(state_q == ST_ARMED) &&
     $past(cfg_q.src == mts_pkg::MTS_SRC_MAN)) |-> $past(manual_trigger);
  endproperty
  a_manual_only: assert property (p_manual_only)
    else $error("manual source fired without command");

  property p_falling_edge;
    (state_q == ST_DELAY && $past(state_q == ST_ARMED) &&
     $past(cfg_q.src == mts_pkg::MTS_SRC_EXT) &&
     $past(cfg_q.slope == mts_pkg::MTS_SL_FALL)) |-> $past(first_external_trigger_p_q) && !$past(first_external_trigger_cur);
  endproperty
  a_falling_edge: assert property (p_falling_edge)
    else $error("falling slope fired without falling edge");

  property p_disabled_idle;
    ($past(clk_en) && !$past(out_cfg_q.enable)) |->
      trigger_output_connector_q == !$past(out_cfg_q.pol_positive);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("pulse on disabled output");

  property p_pulse_end;
    $fell(pulse_active_q) |-> $past(width_done) || !$past(out_cfg_q.enable);
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("pulse ended before programmed width");

  property p_pulse_cause;
    $rose(pulse_active_q) |-> $past(out_cfg_q.interval_point ? (point_begin | point_end)
                                                               : (sweep_begin | sweep_end));
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("pulse without interval event");

  property p_no_retrigger;
    dly_load |-> state_q == ST_ARMED && !seq_busy_q;
  endproperty
  a_no_retrigger: assert property (p_no_retrigger)
    else $error("trigger taken while sequence pending");

  c_segment: cover property (start_segment_q);
  c_multi_and: cover property (dly_load && cfg_q.src == mts_pkg::MTS_SRC_MULTI &&
                               mcfg.src == mts_pkg::MTS_MS_AND);
  c_pulse: cover property ($fell(pulse_active_q) ##1 !pulse_active_q);
  c_run_done: cover property (state_q == ST_RUN ##1 state_q == ST_ARMED);
endmodule

// ===== verilog/mts_params.svh
// Functional notes
// - wait programmable 10 ms-step delay before starting
// - sweep starts sweep; segment starts segment if segmented
// - point starts next point; partial starts partial measurement
// - sources: free run, external, manual, multiple
// - first external from connector or user I/O
// - manual source fires only on manual command
// - qualifier: rising, falling, high level, low level
// - multiple mode: slope per external per granularity
// - multiple mode: source per granularity, six choices
// - second external on its own user I/O line
// - multiple mode: delay per granularity, default zero
// - output enable per channel, off after reset
// - output pulses: width, polarity, before or after
// - pulse width 1 us to 1 s, default 1 us
// - interval per point or per sweep, default sweep
// - polarity positive or negative, default negative
// - placement before or after, default after
`ifndef MTS_PARAMS_SVH
`define MTS_PARAMS_SVH
`define MTS_CLK_PERIOD_NS 100
`define MTS_DELAY_STEP_NS 10000000
`define MTS_DELAY_MAX_S 13680
`define MTS_DELAY_W 21
`define MTS_DELAY_RST 21'h000000
`define MTS_WIDTH_UNIT_NS 1000
`define MTS_WIDTH_MAX_US 1000000
`define MTS_WIDTH_W 20
`define MTS_WIDTH_RST 20'h00001
`endif

// ===== verilog/mts_pkg.sv
`include "mts_params.svh"
package mts_pkg;
  typedef enum logic [1:0] {MTS_SRC_FREE, MTS_SRC_EXT, MTS_SRC_MAN, MTS_SRC_MULTI} mts_src_t;
  typedef enum logic [1:0] {MTS_GR_SWEEP, MTS_GR_SEGMENT, MTS_GR_POINT, MTS_GR_PARTIAL} mts_gran_t;
  typedef enum logic [2:0] {
    MTS_MS_FREE, MTS_MS_FIRST_EXTERNAL_TRIGGER, MTS_MS_SECOND_EXTERNAL_TRIGGER, MTS_MS_AND, MTS_MS_OR, MTS_MS_MAN
  } mts_msrc_t;
  typedef enum logic [1:0] {MTS_SL_RISE, MTS_SL_FALL, MTS_SL_HIGH, MTS_SL_LOW} mts_slope_t;
  typedef struct packed {
    mts_msrc_t src;
    mts_slope_t slope1;
    mts_slope_t slope2;
    logic [`MTS_DELAY_W-1:0] delay;
  } mts_multi_cfg_t;
  typedef struct packed {
    mts_src_t src;
    mts_gran_t gran;
    mts_slope_t slope;
    logic first_external_trigger_from_user_io;
    logic [`MTS_DELAY_W-1:0] delay;
    mts_multi_cfg_t [3:0] multi;
  } mts_trig_cfg_t;
  typedef struct packed {
    logic enable;
    logic [`MTS_WIDTH_W-1:0] width;
    logic interval_point;
    logic pos_before;
    logic pol_positive;
  } mts_out_cfg_t;
endpackage

// ===== verilog/mts_step_timer.sv
`timescale 1ns/1ps
module mts_step_timer #(
  parameter int STEP_CYC = 10,
  parameter int W = 20
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [W-1:0] steps,
  output logic done_q,
  output logic busy_q
);
  localparam int PW = $clog2(STEP_CYC + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(STEP_CYC - 1);
  logic [PW-1:0] pre_q;
  logic [W-1:0] cnt_q;

  if (STEP_CYC < 1 || W < 1) begin : g_chk
    $error("mts_step_timer: step and width must be at least one");
  end

  // counts steps of STEP_CYC cycles, one-cycle done when all elapsed
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pre_q <= '0;
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      if (load) begin
        pre_q <= '0;
        cnt_q <= steps;
        busy_q <= (steps != '0);
        done_q <= (steps == '0);
      end else if (busy_q) begin
        if (pre_q == PRE_LAST) begin
          pre_q <= '0;
          cnt_q <= cnt_q - W'(1);
          if (cnt_q == W'(1)) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end else begin
          pre_q <= pre_q + PW'(1);
        end
      end
    end
  end
endmodule

// ===== bench/mts_ext_equip.sv
`timescale 1ns/1ps
module mts_ext_equip (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic line,
  input wire logic pol_positive,
  output int pulses,
  output int last_width
);
  int run;
  // count active cycles of each received pulse, log it when the line goes idle
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pulses <= 0;
      last_width <= 0;
      run <= 0;
    end else if (line === pol_positive) begin
      run <= run + 1;
    end else if (run != 0) begin
      pulses <= pulses + 1;
      last_width <= run;
      run <= 0;
    end
  end
endmodule

// ===== bench/tb_mts_trigger_sequencer.sv
`timescale 1ns/1ps
module tb_mts_trigger_sequencer;
  localparam int STEP = 4;
  typedef struct {
    int src, gran, sl1, sl2, uio, msrc, dly, seg, ev, exp;
  } mts_row_t;
  mts_row_t rows[$];
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic trig_cfg_wr = 1'b0;
  logic out_cfg_wr = 1'b0;
  mts_pkg::mts_trig_cfg_t trig_cfg = '0;
  mts_pkg::mts_out_cfg_t out_cfg = '0;
  logic conn = 1'b0;
  logic uio1 = 1'b0;
  logic uio2 = 1'b0;
  logic man = 1'b0;
  logic seg = 1'b0;
  logic seq_done = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] eng_ev = 4'h0;
  logic pol = 1'b0;
  logic s_sw, s_sg, s_pt, s_pp, busy, out_line;
  int pulses, last_width, errors = 0, num_checks = 0;

  // clock: 100 ns period
  always #50 ref_clk = ~ref_clk;

  mts_trigger_sequencer #(.DELAY_STEP_CYC(STEP)) mts_trigger_sequencer_inst (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .trig_cfg_wr(trig_cfg_wr), .trig_cfg(trig_cfg),
    .out_cfg_wr(out_cfg_wr), .out_cfg(out_cfg),
    .trigger_input_connector(conn), .user_io_first_ext(uio1),
    .user_io_second_ext(uio2), .manual_trigger(man), .segmented_sweep(seg),
    .seq_done(seq_done), .sweep_begin(eng_ev[3]), .sweep_end(eng_ev[2]),
    .point_begin(eng_ev[1]), .point_end(eng_ev[0]),
    .start_sweep_q(s_sw), .start_segment_q(s_sg), .start_point_q(s_pt),
    .start_partial_q(s_pp), .seq_busy_q(busy), .trigger_output_connector_q(out_line)
  );

  mts_ext_equip mts_ext_equip_inst (
    .ref_clk(ref_clk), .nrst(nrst), .line(out_line), .pol_positive(pol),
    .pulses(pulses), .last_width(last_width)
  );

  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      errors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  task automatic add(input int a, b, c, d, e, f, g, h, i, j);
    rows.push_back('{a, b, c, d, e, f, g, h, i, j});
  endtask

  // write config, re-arm, fire the row's event and time the start strobe
  task automatic run_row(input mts_row_t r);
    mts_pkg::mts_trig_cfg_t c;
    bit fr;
    int k;
    logic [3:0] s;
    fr = (r.src == 0) || (r.src == 3 && r.msrc == 0);
    c = '0;
    c.src = mts_pkg::mts_src_t'(r.src);
    c.gran = mts_pkg::mts_gran_t'(r.gran);
    c.slope = mts_pkg::mts_slope_t'(r.sl1);
    c.first_external_trigger_from_user_io = 1'(r.uio);
    c.delay = (r.src == 3) ? 21'h00006 : 21'(r.dly);
    for (int g = 0; g < 4; g++) c.multi[g].delay = 21'h00005;
    c.multi[r.gran].src = mts_pkg::mts_msrc_t'(r.msrc);
    c.multi[r.gran].slope1 = mts_pkg::mts_slope_t'(r.sl1);
    c.multi[r.gran].slope2 = mts_pkg::mts_slope_t'(r.sl2);
    c.multi[r.gran].delay = 21'(r.dly);
    @(posedge ref_clk);
    trig_cfg <= c;
    trig_cfg_wr <= 1'b1;
    seg <= 1'(r.seg);
    conn <= 1'(r.sl1);
    uio1 <= 1'(r.sl1);
    uio2 <= 1'(r.sl2);
    @(posedge ref_clk);
    trig_cfg_wr <= 1'b0;
    seq_done <= 1'b1;
    if (!fr) begin
      repeat (3) begin
        @(posedge ref_clk);
        seq_done <= 1'b0;
      end
      #1;
      chk(busy === 1'b0, "armed without event");
      @(posedge ref_clk);
      if (r.ev[0] && r.uio != 0) uio1 <= ~1'(r.sl1);
      if (r.ev[0] && r.uio == 0) conn <= ~1'(r.sl1);
      if (r.ev[1]) uio2 <= ~1'(r.sl2);
      man <= r.ev[2];
    end
    k = 0;
    s = 4'h0;
    while (s === 4'h0 && k < 200) begin
      @(posedge ref_clk);
      seq_done <= 1'b0;
      if (k == 0) begin
        conn <= 1'(r.sl1);
        uio1 <= 1'(r.sl1);
        uio2 <= 1'(r.sl2);
        man <= 1'b0;
      end
      #1;
      k++;
      s = {s_sw, s_sg, s_pt, s_pp};
    end
    chk(s === 4'(r.exp), "start kind");
    chk(k == r.dly * STEP + (fr ? 3 : 2), "start latency");
  endtask

  // one engine event, then the received pulse count and width
  task automatic fire(input int i, input int np, input int w);
    int p0;
    p0 = pulses;
    @(posedge ref_clk);
    eng_ev[i] <= 1'b1;
    @(posedge ref_clk);
    eng_ev[i] <= 1'b0;
    repeat (w * 10 + 10) @(posedge ref_clk);
    #1;
    chk(pulses - p0 == np, "pulse count");
    if (np != 0) chk(last_width == w * 10, "pulse width");
  endtask

  task automatic set_out(input logic en, input logic [19:0] w, input logic ip, bf, pp);
    @(posedge ref_clk);
    out_cfg <= '{en, w, ip, bf, pp};
    out_cfg_wr <= 1'b1;
    // the receiver follows the new polarity at once, so an idle shift settles here
    pol <= pp;
    @(posedge ref_clk);
    out_cfg_wr <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #(6000 * 100);
    errors++;
    end_of_test();
  end

  // main sequence
  initial begin
    int sn;
    add(1, 0, 0, 0, 0, 0, 0, 0, 1, 8);
    add(1, 0, 1, 0, 1, 0, 1, 0, 1, 8);
    add(1, 2, 2, 0, 0, 0, 2, 0, 1, 2);
    add(1, 3, 3, 0, 0, 0, 0, 0, 1, 1);
    add(1, 1, 0, 0, 0, 0, 0, 1, 1, 4);
    add(1, 1, 0, 0, 0, 0, 0, 0, 1, 8);
    add(2, 0, 0, 0, 0, 0, 1, 0, 4, 8);
    add(3, 2, 1, 0, 0, 1, 0, 0, 1, 2);
    add(3, 1, 0, 2, 0, 2, 1, 1, 2, 4);
    add(3, 3, 0, 0, 1, 3, 0, 0, 3, 1);
    add(3, 0, 0, 3, 0, 4, 2, 0, 2, 8);
    add(3, 2, 0, 0, 0, 5, 0, 0, 4, 2);
    add(3, 0, 0, 0, 0, 0, 1, 0, 0, 8);
    add(0, 0, 0, 0, 0, 0, 2, 0, 0, 8);
    repeat (10) @(posedge ref_clk);
    #1;
    chk(busy === 1'b0 && out_line === 1'b1, "reset outputs");
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    foreach (rows[i]) run_row(rows[i]);
    run_row(rows[0]);
    sn = 0;
    repeat (8) begin
      @(posedge ref_clk);
      conn <= ~conn;
      @(posedge ref_clk);
      #1;
      if ({s_sw, s_sg, s_pt, s_pp} !== 4'h0) sn++;
    end
    chk(sn == 0 && busy === 1'b1, "retrigger while busy");
    // clock enable low freezes the sequence: the end pulse is not taken
    @(posedge ref_clk);
    clk_en <= 1'b0;
    seq_done <= 1'b1;
    repeat (2) @(posedge ref_clk);
    clk_en <= 1'b1;
    #1;
    chk(busy === 1'b1, "clock enable freeze");
    @(posedge ref_clk);
    seq_done <= 1'b0;
    #1;
    chk(busy === 1'b0, "re-arm after freeze");
    // widths stay below the event spacing used here
    fire(2, 0, 1);
    set_out(1'b1, 20'h00001, 1'b0, 1'b0, 1'b0);
    fire(3, 0, 1);
    fire(0, 0, 1);
    fire(2, 1, 1);
    set_out(1'b1, 20'h00002, 1'b1, 1'b1, 1'b1);
    fire(1, 1, 2);
    fire(2, 0, 2);
    set_out(1'b0, 20'h00002, 1'b1, 1'b1, 1'b1);
    fire(1, 0, 2);
    chk(out_line === 1'b0, "idle level");
    // reset in mid-run restores negative idle and the free-run source
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(out_line === 1'b1 && busy === 1'b0, "mid-run reset");
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(busy === 1'b1, "free run after reset");
    end_of_test();
  end
endmodule
